// *** design/lcr_defs.svh ***
// constants for the lane clock, reset and receive user port block
`ifndef LCR_DEFS_SVH
`define LCR_DEFS_SVH
`define LCR_LANES        12
`define LCR_LANE_W       64
`define LCR_SEG_W        128
`define LCR_SEGS         3
`define LCR_UNITS        6
`define LCR_UNIT_CNT_W   3
`define LCR_FIFO_DEPTH   16
`define LCR_SYNC_ASSERT  2'b11
`define LCR_SYNC_RELEASE 2'b00
`endif

// *** design/lcr_pkg.sv ***
// types shared by the lane clock, reset and receive user port block
`include "lcr_defs.svh"
package lcr_pkg;
   typedef logic [`LCR_LANE_W-1:0] lcr_lane_word_type;
   typedef logic [`LCR_SEG_W-1:0]  lcr_seg_word_type;
   typedef logic [`LCR_LANES-1:0]  lcr_lane_vec_type;
   typedef logic [`LCR_SEGS-1:0]   lcr_seg_vec_type;
endpackage

// *** design/lcr_fifo.sv ***
// single-clock rate-adapting fifo with valid/ready on both sides
`timescale 1ns/1ns
`include "lcr_defs.svh"
module lcr_fifo #(
   parameter int WIDTH = `LCR_SEG_W,
   parameter int DEPTH = `LCR_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   input  wire logic [WIDTH-1:0] wr_data,
   output logic                  rd_valid,
   input  wire logic             rd_ready,
   output logic      [WIDTH-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   wire              do_wr = wr_valid & wr_ready;
   wire              do_rd = rd_valid & rd_ready;
   wire [AW:0]       depth_c = (AW+1)'(DEPTH);

   assign wr_ready = (count != depth_c);
   assign rd_valid = (count != '0);
   assign rd_data  = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (do_wr)
         mem[wr_ptr] <= wr_data;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_wr)
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (do_rd)
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule

// *** design/lcr_rx_port.sv ***
// lane capture, reset synchronisers and receive segmented user port
`timescale 1ns/1ns
`include "lcr_defs.svh"
module lcr_rx_port
   import lcr_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire logic [`LCR_LANES-1:0]  lane_recovered_clk,
   input  wire logic [`LCR_LANES-1:0]  lane_rx_rst,
   input  wire lcr_lane_word_type      lane_rx_word [`LCR_LANES],
   input  wire logic                   tx_ref_clk,
   input  wire logic                   tx_ref_clk_rst,
   input  wire logic                   user_bus_clk,
   input  wire logic                   rx_rst,
   input  wire logic                   tx_rst,
   output lcr_seg_word_type            rx_seg0_payload,
   output lcr_seg_word_type            rx_seg1_payload,
   output lcr_seg_word_type            rx_seg2_payload,
   output lcr_seg_vec_type             rx_seg_valid,
   output logic                        rx_fifo_overflow,
   output logic                        tx_path_rst
);
   // async assert, clocked release; only the first flop takes a constant
   logic [1:0] rx_rst_sync;
   logic [1:0] tx_rst_sync;

   always_ff @(posedge clk or posedge rx_rst) begin
      if (rx_rst)
         rx_rst_sync <= `LCR_SYNC_ASSERT;
      else
         rx_rst_sync <= {rx_rst_sync[0], 1'b0};
   end

   always_ff @(posedge clk or posedge tx_rst) begin
      if (tx_rst)
         tx_rst_sync <= `LCR_SYNC_ASSERT;
      else
         tx_rst_sync <= {tx_rst_sync[0], 1'b0};
   end

   wire rx_hold = ~rstn | rx_rst_sync[1];

   // pin synchronisers for the user and tx reference clocks
   logic [2:0] ubc_sync;
   logic [2:0] trc_sync;
   logic [1:0] trr_sync;
   always_ff @(posedge clk) begin
      ubc_sync <= {ubc_sync[1:0], user_bus_clk};
      trc_sync <= {trc_sync[1:0], tx_ref_clk};
      trr_sync <= {trr_sync[0], tx_ref_clk_rst};
   end
   wire user_edge = ubc_sync[1] & ~ubc_sync[2];
   wire tref_edge = trc_sync[1] & ~trc_sync[2];

   // tx path stays in reset until the reference clock is seen toggling
   logic tref_seen;
   always_ff @(posedge clk) begin
      if (!rstn || tx_rst_sync[1] || trr_sync[1]) begin
         tref_seen   <= 1'b0;
         tx_path_rst <= 1'b1;
      end else begin
         if (tref_edge)
            tref_seen <= 1'b1;
         tx_path_rst <= ~tref_seen;
      end
   end

   // per-lane capture
   logic [1:0]        lrst_sync [`LCR_LANES];
   lcr_lane_vec_type  pending;
   lcr_lane_vec_type  lost;
   lcr_lane_vec_type  lane_take;
   lcr_lane_word_type lane_word [`LCR_LANES];
   wire               stripe_done = &pending;
   logic [`LCR_UNIT_CNT_W-1:0] stage_cnt;
   wire               stage_load = stripe_done & (stage_cnt == '0);

   genvar g;
   generate
      for (g = 0; g < `LCR_LANES; g++) begin : gen_lane
         logic [2:0]        lclk_sync;
         lcr_lane_word_type w_s1;
         lcr_lane_word_type w_s2;
         lcr_lane_word_type w_mid;
         wire rise = lclk_sync[1] & ~lclk_sync[2];
         wire fall = ~lclk_sync[1] & lclk_sync[2];
         wire lane_ok = ~lrst_sync[g][1];
         assign lane_take[g] = rise & lane_ok;
         assign lost[g] = lane_take[g] & pending[g] & ~stage_load;

         always_ff @(posedge clk) begin
            lclk_sync    <= {lclk_sync[1:0], lane_recovered_clk[g]};
            lrst_sync[g] <= {lrst_sync[g][0], lane_rx_rst[g]};
            w_s1         <= lane_rx_word[g];
            w_s2         <= w_s1;
         end

         // mid-period copy is what the lane clock rising edge would see
         always_ff @(posedge clk) begin
            if (fall)
               w_mid <= w_s2;
         end

         always_ff @(posedge clk) begin
            if (rx_hold || !lane_ok) begin
               pending[g]   <= 1'b0;
               lane_word[g] <= '0;
            end else if (lane_take[g]) begin
               pending[g]   <= 1'b1;
               lane_word[g] <= w_mid;
            end else if (stage_load) begin
               pending[g]   <= 1'b0;
            end
         end
      end
   endgenerate

   // stripe staging: six 128-bit units, two lanes each
   lcr_lane_word_type stage [`LCR_LANES];
   logic              fifo_wr_ready;
   wire               stage_valid = (stage_cnt != '0);
   wire [`LCR_UNIT_CNT_W-1:0] unit_idx =
      `LCR_UNIT_CNT_W'(`LCR_UNITS) - stage_cnt;
   // even lane is earlier on the line, so it takes the upper half
   wire lcr_seg_word_type unit_word =
      {stage[{unit_idx, 1'b0}], stage[{unit_idx, 1'b1}]};

   always_ff @(posedge clk) begin
      if (stage_load)
         stage <= lane_word;
   end

   always_ff @(posedge clk) begin
      if (rx_hold)
         stage_cnt <= '0;
      else if (stage_load)
         stage_cnt <= `LCR_UNIT_CNT_W'(`LCR_UNITS);
      else if (stage_valid && fifo_wr_ready)
         stage_cnt <= stage_cnt - 1'b1;
   end

   // rate-adapting fifo between lane side and user side
   logic             fifo_rd_valid;
   logic             fifo_rd_ready;
   lcr_seg_word_type fifo_rd_data;

   lcr_fifo #(
      .WIDTH (`LCR_SEG_W),
      .DEPTH (`LCR_FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst      (rx_hold),
      .wr_valid (stage_valid),
      .wr_ready (fifo_wr_ready),
      .wr_data  (unit_word),
      .rd_valid (fifo_rd_valid),
      .rd_ready (fifo_rd_ready),
      .rd_data  (fifo_rd_data)
   );

   // user side gathers up to three units between user clock edges
   lcr_seg_word_type asm_word [`LCR_SEGS];
   logic [1:0]       asm_cnt;
   wire  [1:0]       segs_c = 2'(`LCR_SEGS);
   // no pop on the edge cycle, so a unit is never half-presented
   assign fifo_rd_ready = (asm_cnt != segs_c) & ~user_edge;
   wire pop = fifo_rd_valid & fifo_rd_ready;

   always_ff @(posedge clk) begin
      if (pop)
         asm_word[asm_cnt] <= fifo_rd_data;
   end

   always_ff @(posedge clk) begin
      if (rx_hold)
         asm_cnt <= '0;
      else if (user_edge)
         asm_cnt <= '0;
      else if (pop)
         asm_cnt <= asm_cnt + 1'b1;
   end

   // valid mask from the number of gathered units, segment zero first
   wire lcr_seg_vec_type next_valid = lcr_seg_vec_type'(
      (4'h1 << asm_cnt) - 4'h1);

   always_ff @(posedge clk) begin
      if (rx_hold) begin
         rx_seg0_payload <= '0;
         rx_seg1_payload <= '0;
         rx_seg2_payload <= '0;
         rx_seg_valid    <= '0;
      end else if (user_edge) begin
         // unused segments present zero; valid low marks them void
         rx_seg0_payload <= next_valid[0] ? asm_word[0] : '0;
         rx_seg1_payload <= next_valid[1] ? asm_word[1] : '0;
         rx_seg2_payload <= next_valid[2] ? asm_word[2] : '0;
         rx_seg_valid    <= next_valid;
      end
   end

   // sticky until receive or block reset; a lane word overwritten is data lost
   always_ff @(posedge clk) begin
      if (rx_hold)
         rx_fifo_overflow <= 1'b0;
      else if (|lost)
         rx_fifo_overflow <= 1'b1;
   end
endmodule

// *** tb/lcr_rx_monitor.sv ***
// port checker for the lane capture and receive user port
`timescale 1ns/1ns
module lcr_rx_monitor
   import lcr_pkg::*;
(
   input wire logic             clk,
   input wire logic             rstn,
   input wire logic             rx_rst,
   input wire logic             tx_rst,
   input wire logic             tx_ref_clk_rst,
   input wire logic             user_bus_clk,
   input wire lcr_seg_word_type rx_seg0_payload,
   input wire lcr_seg_word_type rx_seg1_payload,
   input wire lcr_seg_word_type rx_seg2_payload,
   input wire lcr_seg_vec_type  rx_seg_valid,
   input wire logic             rx_fifo_overflow,
   input wire logic             tx_path_rst
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   valid_shape_a:
   assert property (rx_seg_valid inside {3'h0, 3'h1, 3'h3, 3'h7})
      else $error("segment valid not filled from segment zero");
   idle_zero_a:
   assert property ((rx_seg_valid[0] || rx_seg0_payload == '0) &&
      (rx_seg_valid[1] || rx_seg1_payload == '0) &&
      (rx_seg_valid[2] || rx_seg2_payload == '0))
      else $error("payload not zero while its valid is low");
   reset_clear_a:
   assert property (disable iff (1'b0)
      !rstn |=> rx_seg_valid == '0 && !rx_fifo_overflow)
      else $error("outputs not cleared by block reset");
   ovf_sticky_a:
   assert property (rx_fifo_overflow && !rx_rst |=>
      rx_fifo_overflow || rx_rst)
      else $error("overflow dropped without receive reset");
   rx_hold_a:
   assert property (rx_rst [*3] |-> rx_seg_valid == '0 && !rx_fifo_overflow)
      else $error("receive reset did not hold outputs clear");
   tx_hold_a:
   assert property (tx_rst |=> tx_path_rst)
      else $error("transmit reset not passed on");
   ref_hold_a:
   // two sync flops plus the reset flop: the pin must stand four samples
   assert property (tx_ref_clk_rst [*4] |-> tx_path_rst)
      else $error("tx path left reset while reference unlocked");
   user_sync_a:
   assert property (disable iff (!rstn || rx_rst)
      (!user_bus_clk) [*5] |->
      $stable(rx_seg_valid) && $stable(rx_seg0_payload))
      else $error("user outputs changed without a user clock edge");
endmodule

// *** tb/lcr_user_model.sv ***
// user side logic model: makes the user bus clock at two rates
`timescale 1ns/1ns
module lcr_user_model (
   input  wire logic slow,
   output logic      user_bus_clk
);
   // fast: 3 units per 60 ns beats 6 per 125 ns; slow lets the fifo overflow on purpose
   initial user_bus_clk = 1'b0;
   always #(slow ? 200 : 30) user_bus_clk = ~user_bus_clk;
endmodule

// *** tb/tb.sv ***
// self-checking bench for the lane capture and receive user port
`timescale 1ns/1ns
`include "lcr_defs.svh"
module tb
   import lcr_pkg::*;
;
   logic              clk = 1'b0;
   logic              rstn = 1'b0;
   logic              rx_rst = 1'b1;
   logic              tx_rst = 1'b1;
   logic              tx_ref_clk = 1'b0;
   logic              tx_ref_clk_rst = 1'b1;
   logic              slow = 1'b0;
   logic              skip = 1'b0;
   lcr_lane_vec_type  lck = '1;
   lcr_lane_vec_type  lane_rx_rst = '1;
   lcr_lane_word_type lane_rx_word [`LCR_LANES];
   lcr_seg_word_type  seg [`LCR_SEGS];
   lcr_seg_word_type  q [$];
   lcr_seg_vec_type   rx_seg_valid;
   logic              user_bus_clk, rx_fifo_overflow, tx_path_rst;
   int                error_cnt = 0;
   int                n_checks = 0;
   // block clock scaled down; link and user clocks scaled with it
   always #5 clk = ~clk;
   always #32 tx_ref_clk = ~tx_ref_clk;
   lcr_user_model u_user (.slow(slow), .user_bus_clk(user_bus_clk));
   lcr_rx_port dut (.clk(clk), .rstn(rstn), .lane_recovered_clk(lck),
      .lane_rx_rst(lane_rx_rst), .lane_rx_word(lane_rx_word),
      .tx_ref_clk(tx_ref_clk), .tx_ref_clk_rst(tx_ref_clk_rst),
      .user_bus_clk(user_bus_clk), .rx_rst(rx_rst), .tx_rst(tx_rst),
      .rx_seg0_payload(seg[0]), .rx_seg1_payload(seg[1]),
      .rx_seg2_payload(seg[2]), .rx_seg_valid(rx_seg_valid),
      .rx_fifo_overflow(rx_fifo_overflow), .tx_path_rst(tx_path_rst));
   task automatic check(input lcr_seg_word_type got,
                        input lcr_seg_word_type exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one word per lane per stripe; clock idles high between stripes and
   // its edges sit at least 1 ns off the block clock edges, so no sampling race
   task automatic stripes(input int n);
      #2;
      repeat (n) begin
         foreach (lane_rx_word[m]) lane_rx_word[m] = {$urandom, $urandom};
         if (!skip)
            for (int j = 0; j < `LCR_UNITS; j++)
               q.push_back({lane_rx_word[2*j],
                            lane_rx_word[2*j+1]});
         #62 lck = '0;
         #63 lck = '1;
      end
   endtask
   // outputs stand a whole user period, so look well after the edge
   always @(posedge user_bus_clk) begin
      repeat (5) @(posedge clk);
      #1;
      for (int k = 0; k < `LCR_SEGS; k++)
         if (rx_seg_valid[k] === 1'b1 && !skip) begin
            check(seg[k], q.size() ? q.pop_front() : ~seg[k]);
         end
   end
   initial begin
      int i;
      foreach (lane_rx_word[n]) lane_rx_word[n] = '0;
      void'($urandom(32'hf322));
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      rx_rst = 1'b0;
      tx_rst = 1'b0;
      lane_rx_rst = '0;
      repeat (10) @(negedge clk);
      check(128'(tx_path_rst), 128'h1);
      tx_ref_clk_rst = 1'b0;
      for (i = 0; i < 30 && tx_path_rst !== 1'b0; i++)
         @(negedge clk);
      if (i == 30) begin
         error_cnt++;
         give_verdict();
      end
      check(128'(tx_path_rst), 128'h0);
      stripes(8);
      repeat (40) @(negedge clk);
      check(128'(q.size()), 128'h0);
      check(128'(rx_fifo_overflow), 128'h0);
      skip = 1'b1;
      slow = 1'b1;
      stripes(10);
      check(128'(rx_fifo_overflow), 128'h1);
      @(negedge clk);
      rx_rst = 1'b1;
      tx_rst = 1'b1;
      repeat (3) @(negedge clk);
      check(128'(rx_fifo_overflow), 128'h0);
      check(128'(rx_seg_valid), 128'h0);
      check(128'(tx_path_rst), 128'h1);
      slow = 1'b0;
      rx_rst = 1'b0;
      tx_rst = 1'b0;
      repeat (4) @(negedge clk);
      skip = 1'b0;
      q.delete();
      stripes(4);
      repeat (40) @(negedge clk);
      check(128'(q.size()), 128'h0);
      check(128'(tx_path_rst), 128'h0);
      give_verdict();
   end
endmodule
bind lcr_rx_port lcr_rx_monitor u_mon (.clk(clk), .rstn(rstn),
   .rx_rst(rx_rst), .tx_rst(tx_rst), .tx_ref_clk_rst(tx_ref_clk_rst),
   .user_bus_clk(user_bus_clk), .rx_seg0_payload(rx_seg0_payload),
   .rx_seg1_payload(rx_seg1_payload), .rx_seg2_payload(rx_seg2_payload),
   .rx_seg_valid(rx_seg_valid), .rx_fifo_overflow(rx_fifo_overflow),
   .tx_path_rst(tx_path_rst));
